/* File: include/sleep_ctl_map.svh */
// Offsets, field positions, reset values and timing counts of the sleep and clock-stop block.
// Included by the design files and the testbench; definitions only.
`ifndef SLEEP_CTL_MAP_SVH
`define SLEEP_CTL_MAP_SVH

// ==========================================================
// Register offsets (byte addresses on APB)
`define OFS_SLEEP_MODE_CONTROL 12'h000
`define OFS_PERIPHERAL_CLOCK_STOP 12'h004
`define OFS_SLEEP_STATUS 12'h008

// ==========================================================
// Field positions
`define SMC_ENABLE_BIT 0
`define SMC_MODE_LSB 1
`define PCS_CONVERTER_BIT 0
`define PCS_UNUSED_BIT 1
`define PCS_WRITE_MASK 8'hFD

// ==========================================================
// Reset values
`define SMC_RESET 4'h0
`define PCS_RESET 8'h00

// ==========================================================
// Sleep mode codes
`define MODE_IDLE 3'h0
`define MODE_NOISE 3'h1
`define MODE_POWER_DOWN 3'h2
`define MODE_STANDBY 3'h6

// ==========================================================
// Timing counts in system clock cycles, and the start-up counter width in bits
`define HALT_EXTRA_CYCLES 4'h4
`define STANDBY_WAKE_CYCLES 4'h6
`define STARTUP_CNT_W 16

`endif

/* File: include/sleep_ctl_pkg.sv */
// Types shared by the sleep and clock-stop block.
// Assumes nothing of its surroundings.
package sleep_ctl_pkg;

    // Sleep sequencer states, one-hot.
    typedef enum logic [5:0] {
        ST_ACTIVE = 6'h01,
        ST_SLEEP = 6'h02,
        ST_STARTUP = 6'h04,
        ST_HALT = 6'h08,
        ST_DEEP = 6'h10,
        ST_WAKE_STBY = 6'h20
    } sleep_state_t;

    // Clock domain enables towards the clock tree.
    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic converter;
        logic pll;
        logic main_source;
    } clock_domains_t;

    // Per-peripheral clock enables.
    typedef struct packed {
        logic power_stage2;
        logic power_stage1;
        logic power_stage0;
        logic timer1;
        logic timer0;
        logic serial_periph;
        logic converter;
    } module_clocks_t;

    // Analog helper controls.
    typedef struct packed {
        logic comparator_enable;
        logic comparator_mux_allow;
        logic reference_enable;
        logic brownout_enable;
        logic converter_enable;
        logic converter_extended;
    } analog_ctl_t;

endpackage

/* File: logic/wake_counter.sv */
// Down counter that times the start-up wait and the extra halt cycles after wake-up.
// Assumes a load pulse with a nonzero count; done is a one-cycle pulse at the end.
`timescale 1ns/100ps
`include "sleep_ctl_map.svh"

module wake_counter
    import sleep_ctl_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic reset_in,
    // Control.
    input wire logic load_in,
    input wire logic [`STARTUP_CNT_W-1:0] count_in,
    // Status.
    output logic busy_out,
    output logic done_out
);

    logic [`STARTUP_CNT_W-1:0] remain;

    // ==========================================================
    // Counter
    // Loads the count and runs it down to zero.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            remain <= '0;
        end else if (load_in) begin
            remain <= count_in;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    // Done marks the last counted cycle, so the state that owns a count of N lasts exactly N cycles.
    assign done_out = (remain == {{(`STARTUP_CNT_W-1){1'b0}}, 1'b1});

    // Busy while a count runs.
    assign busy_out = (remain != '0);

endmodule

/* File: logic/sleep_clock_control.sv */
// Sleep sequencer, clock domain gating and per-peripheral clock stop with an APB register slave.
// Assumes a core that pulses sleep_instr_in and waits on cpu_run_out, and fuse values held stable.
//
// Summary of operation
// - Hold core four cycles after start-up.
// - Code 010 enters power-down, oscillator stopped.
// - Power-down wakes on resets, stage, level interrupts.
// - Power-down stops every generated clock.
// - Power-down exit waits fuse-set start-up time.
// - Code 110 with crystal enters standby.
// - Standby resumes within six cycles.
// - Each mode keeps its listed domains running.
// - Stop bit gates clock, freezes, blocks access.
// - Clearing stop bit restores prior state.
// - Stop register bit map, reset zero.
// - Timer stop bits leave enabled timers running.
// - Stopped converter denies comparator its multiplexer.
// - Module stop acts outside deep modes and start-up.
// - Enabled converter stays on; restart extended conversion.
// - Deep modes disable comparator unless reference used.
// - Reference on only when someone needs it.
// - Fuse-enabled brown-out stays on in sleep.
`timescale 1ns/100ps
`include "sleep_ctl_map.svh"

module sleep_clock_control
    import sleep_ctl_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic reset_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Core interface.
    input wire logic sleep_instr_in,
    input wire logic irq_enabled_in,
    output logic cpu_run_out,
    // Wake sources.
    input wire logic [3:0] external_interrupt_lines_in,
    input wire logic power_stage_controller_irq_in,
    input wire logic watchdog_reset_in,
    input wire logic brownout_reset_in,
    input wire logic external_reset_in,
    // Fuses and analog requests.
    input wire logic [`STARTUP_CNT_W-1:0] clock_source_fuses_in,
    input wire logic crystal_selected_in,
    input wire logic [2:0] brownout_level_fuses_in,
    input wire logic converter_on_in,
    input wire logic comparator_on_in,
    input wire logic comparator_uses_ref_in,
    // Clock and analog outputs.
    output clock_domains_t domains_out,
    output module_clocks_t module_clocks_out,
    output analog_ctl_t analog_out
);

    sleep_state_t state;
    sleep_state_t next_state;
    logic [3:0] sleep_mode_control;
    logic [7:0] peripheral_clock_stop;
    logic [2:0] sleep_mode;
    logic [2:0] active_mode;
    logic wake_event;
    logic level_wake;
    logic cnt_load;
    logic [`STARTUP_CNT_W-1:0] cnt_value;
    logic cnt_busy;
    logic cnt_done;
    logic conv_was_on;
    logic conv_extended;
    logic apb_write;

    // Returns one when the mode code is a documented, usable deep or light mode.
    function automatic logic mode_valid(input logic [2:0] code, input logic xtal);
        mode_valid = (code == `MODE_IDLE) || (code == `MODE_NOISE) || (code == `MODE_POWER_DOWN) ||
                     ((code == `MODE_STANDBY) && xtal);
    endfunction

    // Returns one for power-down and standby; every domain stops there except the main source in standby.
    function automatic logic mode_deep(input logic [2:0] code);
        mode_deep = (code == `MODE_POWER_DOWN) || (code == `MODE_STANDBY);
    endfunction

    // ==========================================================
    // APB register slave
    assign pready_out = 1'b1;
    assign apb_write = psel_in && penable_in && pwrite_in;
    assign sleep_mode = sleep_mode_control[`SMC_MODE_LSB +: 3];

    // Sleep mode control register.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            sleep_mode_control <= `SMC_RESET;
        end else if (apb_write && paddr_in == `OFS_SLEEP_MODE_CONTROL) begin
            sleep_mode_control <= pwdata_in[3:0];
        end
    end

    // Peripheral clock stop register; bit 1 is never stored.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            peripheral_clock_stop <= `PCS_RESET;
        end else if (apb_write && paddr_in == `OFS_PERIPHERAL_CLOCK_STOP) begin
            peripheral_clock_stop <= pwdata_in[7:0] & `PCS_WRITE_MASK;
        end
    end

    // Read data and error answer, combinational and valid in the access phase.
    always_comb begin
        prdata_out = 32'h0000_0000;
        pslverr_out = 1'b0;
        case (paddr_in)
            `OFS_SLEEP_MODE_CONTROL: prdata_out = {28'h000_0000, sleep_mode_control};
            `OFS_PERIPHERAL_CLOCK_STOP: prdata_out = {24'h00_0000, peripheral_clock_stop};
            `OFS_SLEEP_STATUS: prdata_out = {26'h0, state};
            default: pslverr_out = psel_in && penable_in;
        endcase
    end

    // ==========================================================
    // Wake detection
    // Power-down and standby wake only on resets, stage interrupt or low level lines.
    assign level_wake = (external_interrupt_lines_in != 4'hF);
    assign wake_event = external_reset_in || watchdog_reset_in || brownout_reset_in ||
                        power_stage_controller_irq_in || level_wake;

    // ==========================================================
    // Sleep sequencer
    always_comb begin
        next_state = state;
        cnt_load = 1'b0;
        cnt_value = clock_source_fuses_in;
        case (state)
            ST_ACTIVE: begin
                // Enter only with enable bit set and a valid mode code.
                if (sleep_instr_in && sleep_mode_control[`SMC_ENABLE_BIT] &&
                    mode_valid(sleep_mode, crystal_selected_in)) begin
                    next_state = mode_deep(sleep_mode) ? ST_DEEP : ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (irq_enabled_in || wake_event) begin
                    next_state = ST_HALT;
                    cnt_load = 1'b1;
                    cnt_value = `STARTUP_CNT_W'(`HALT_EXTRA_CYCLES);
                end
            end
            ST_DEEP: begin
                if (wake_event) begin
                    cnt_load = 1'b1;
                    if (active_mode == `MODE_STANDBY) begin
                        next_state = ST_WAKE_STBY;
                        cnt_value = `STARTUP_CNT_W'(`STANDBY_WAKE_CYCLES);
                    end else begin
                        next_state = ST_STARTUP;
                        cnt_value = (clock_source_fuses_in == '0) ? `STARTUP_CNT_W'(1) :
                                    clock_source_fuses_in;
                    end
                end
            end
            ST_STARTUP: begin
                if (cnt_done) begin
                    next_state = ST_HALT;
                    cnt_load = 1'b1;
                    cnt_value = `STARTUP_CNT_W'(`HALT_EXTRA_CYCLES);
                end
            end
            ST_WAKE_STBY: begin
                if (cnt_done) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_HALT: begin
                if (cnt_done) begin
                    next_state = ST_ACTIVE;
                end
            end
            default: next_state = ST_ACTIVE;
        endcase
    end

    // State register.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= ST_ACTIVE;
        end else begin
            state <= next_state;
        end
    end

    // Mode latched at sleep entry.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            active_mode <= `MODE_IDLE;
        end else if (state == ST_ACTIVE && next_state != ST_ACTIVE) begin
            active_mode <= sleep_mode;
        end
    end

    // Start-up and halt timer.
    wake_counter u_wake_counter (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .load_in(cnt_load),
        .count_in(cnt_value),
        .busy_out(cnt_busy),
        .done_out(cnt_done)
    );

    // ==========================================================
    // Clock domains and module clocks
    // Core runs only while active; domains follow the latched mode.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            cpu_run_out <= 1'b1;
            domains_out <= 6'h3F;
        end else begin
            cpu_run_out <= (next_state == ST_ACTIVE);
            domains_out <= 6'h3F;
            if (next_state == ST_SLEEP) begin
                domains_out <= ((state == ST_ACTIVE ? sleep_mode : active_mode) == `MODE_NOISE) ?
                               6'h07 : 6'h0F;
            end else if (next_state == ST_DEEP) begin
                domains_out <= (state == ST_ACTIVE ? sleep_mode : active_mode) == `MODE_STANDBY ?
                               6'h01 : 6'h00;
            end else if (next_state == ST_STARTUP) begin
                domains_out <= 6'h01;
            end else if (next_state == ST_HALT || next_state == ST_WAKE_STBY) begin
                domains_out <= 6'h1F;
            end
        end
    end

    // Module clocks gated by stop bits; deep modes stop them all anyway.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            module_clocks_out <= 7'h7F;
        end else begin
            module_clocks_out <= ~{peripheral_clock_stop[7:2], peripheral_clock_stop[0]};
            // Timers keep their clock outside deep modes and start-up; their stop bits have no effect.
            module_clocks_out.timer1 <= 1'b1;
            module_clocks_out.timer0 <= 1'b1;
            if (next_state == ST_DEEP || next_state == ST_STARTUP) begin
                module_clocks_out <= 7'h00;
            end
        end
    end

    // ==========================================================
    // Analog helpers
    // Tracks converter off-on cycles to flag an extended next conversion.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            conv_was_on <= 1'b0;
            conv_extended <= 1'b1;
        end else begin
            conv_was_on <= converter_on_in;
            if (converter_on_in && !conv_was_on) begin
                conv_extended <= 1'b1;
            end else if (converter_on_in && domains_out.converter && !peripheral_clock_stop[`PCS_CONVERTER_BIT]) begin
                conv_extended <= 1'b0;
            end
        end
    end

    // Comparator, reference, brown-out and converter enables.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            analog_out <= 6'h00;
        end else begin
            analog_out.converter_enable <= converter_on_in;
            analog_out.converter_extended <= conv_extended;
            analog_out.brownout_enable <= (brownout_level_fuses_in != 3'h7);
            analog_out.comparator_mux_allow <= !peripheral_clock_stop[`PCS_CONVERTER_BIT];
            analog_out.comparator_enable <= comparator_on_in &&
                (next_state != ST_DEEP && next_state != ST_STARTUP || comparator_uses_ref_in);
            analog_out.reference_enable <= (brownout_level_fuses_in != 3'h7) || converter_on_in ||
                (comparator_on_in && comparator_uses_ref_in);
        end
    end

    // ==========================================================
    // Assertions
    AST_NO_SLEEP_WITHOUT_ENABLE: assert property (@(posedge mclk_in) disable iff (reset_in)
        state == ST_ACTIVE && !sleep_mode_control[`SMC_ENABLE_BIT] |=> state == ST_ACTIVE)
        else $error("Sleep entered without enable bit.");
    AST_HALT_FOUR: assert property (@(posedge mclk_in) disable iff (reset_in)
        state != ST_HALT ##1 state == ST_HALT |-> (state == ST_HALT)[*4] ##1 state == ST_ACTIVE)
        else $error("Halt after wake is not four cycles.");
    AST_PD_CLOCKS_OFF: assert property (@(posedge mclk_in) disable iff (reset_in)
        state == ST_DEEP && active_mode == `MODE_POWER_DOWN |-> domains_out == 6'h00)
        else $error("Clock running in power-down.");
    AST_STBY_MAIN_ON: assert property (@(posedge mclk_in) disable iff (reset_in)
        state == ST_DEEP && active_mode == `MODE_STANDBY |-> domains_out == 6'h01)
        else $error("Standby domains wrong.");
    AST_STBY_SIX: assert property (@(posedge mclk_in) disable iff (reset_in)
        state == ST_DEEP && active_mode == `MODE_STANDBY && wake_event |-> ##[1:7] cpu_run_out)
        else $error("Standby wake slower than six cycles.");
    AST_RESERVED_IGNORED: assert property (@(posedge mclk_in) disable iff (reset_in)
        state == ST_ACTIVE && !mode_valid(sleep_mode, crystal_selected_in) |=> state == ST_ACTIVE)
        else $error("Reserved mode code entered sleep.");
    AST_BIT1_ZERO: assert property (@(posedge mclk_in) disable iff (reset_in)
        peripheral_clock_stop[`PCS_UNUSED_BIT] == 1'b0)
        else $error("Unused stop bit set.");
    AST_MUX_DENIED: assert property (@(posedge mclk_in) disable iff (reset_in)
        $rose(peripheral_clock_stop[`PCS_CONVERTER_BIT]) |=> !analog_out.comparator_mux_allow)
        else $error("Comparator kept multiplexer with converter stopped.");
    AST_DEEP_MODULES_OFF: assert property (@(posedge mclk_in) disable iff (reset_in)
        state == ST_DEEP |-> module_clocks_out == 7'h00)
        else $error("Module clock running in deep sleep.");
    AST_BOD_KEPT: assert property (@(posedge mclk_in) disable iff (reset_in)
        !$past(reset_in) && $past(brownout_level_fuses_in) != 3'h7 |-> analog_out.brownout_enable)
        else $error("Brown-out detector dropped.");
    AST_STARTUP_TIMED: assert property (@(posedge mclk_in) disable iff (reset_in)
        state == ST_STARTUP && !cnt_done |=> state == ST_STARTUP && cnt_busy)
        else $error("Start-up left before its wait ran out.");

    COV_POWER_DOWN: cover property (@(posedge mclk_in) disable iff (reset_in)
        state == ST_DEEP && active_mode == `MODE_POWER_DOWN ##[1:100] state == ST_STARTUP);
    COV_STANDBY: cover property (@(posedge mclk_in) disable iff (reset_in) state == ST_WAKE_STBY);
    COV_IDLE_WAKE: cover property (@(posedge mclk_in) disable iff (reset_in) state == ST_SLEEP ##1 state == ST_HALT);
    COV_STOP_SPI: cover property (@(posedge mclk_in) disable iff (reset_in) !module_clocks_out.serial_periph);

endmodule

/* File: testbench/sleep_and_module_clock_gating_tb.sv */
// Self-checking bench for the sleep sequencer and clock-stop block.
// Assumes the map header and package are compiled first; drives every port itself.
`timescale 1ns/100ps
`include "sleep_ctl_map.svh"

module sleep_and_module_clock_gating_tb;
    import sleep_ctl_pkg::*;
    `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
        $display("unexpected %s exp %0h got %0h", nm, e, g); end end

    // ==========================================================
    // Stimulus and observed signals
    logic mclk_in = 1'b0, reset_in = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, sleep_instr = 1'b0, irq_en = 1'b0, cpu_run;
    logic [3:0] ext_lines = 4'hF;
    logic psc_irq = 1'b0, wdt_rst = 1'b0, bod_rst = 1'b0, ext_rst = 1'b0;
    logic [15:0] fuses = 16'h0005;
    logic crystal = 1'b1, conv_on = 1'b0, comp_on = 1'b0, comp_ref = 1'b0;
    logic [2:0] bod_fuses = 3'h3;
    clock_domains_t domains;
    module_clocks_t mclks;
    analog_ctl_t analog;
    int err_count = 0, n_checks = 0, cyc = 0, n;

    // The design under test.
    sleep_clock_control DUT (.mclk_in(mclk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .sleep_instr_in(sleep_instr), .irq_enabled_in(irq_en), .cpu_run_out(cpu_run),
        .external_interrupt_lines_in(ext_lines), .power_stage_controller_irq_in(psc_irq),
        .watchdog_reset_in(wdt_rst), .brownout_reset_in(bod_rst), .external_reset_in(ext_rst),
        .clock_source_fuses_in(fuses), .crystal_selected_in(crystal), .brownout_level_fuses_in(bod_fuses),
        .converter_on_in(conv_on), .comparator_on_in(comp_on), .comparator_uses_ref_in(comp_ref),
        .domains_out(domains), .module_clocks_out(mclks), .analog_out(analog));

    // ==========================================================
    // Clock and hang guard
    always #4 mclk_in = ~mclk_in;

    // A run far beyond the expected length counts as a failure.
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end

    // ==========================================================
    // Shared tasks
    // One APB transfer; read data and error are taken at the edge that sees pready.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        do @(posedge mclk_in); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pulses the sleep instruction and lets the outputs settle.
    task automatic sleep_pulse();
        @(posedge mclk_in);
        sleep_instr <= 1'b1;
        @(posedge mclk_in);
        sleep_instr <= 1'b0;
        repeat (2) @(posedge mclk_in);
        #1;
    endtask

    // Counts settled edges until the core may run again, bounded.
    task automatic wait_run();
        n = 0;
        while (cpu_run !== 1'b1 && n < 60) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
    endtask

    // ==========================================================
    // Scenarios
    // Reset values, bit map, unused bit, timer bits and restart of clocks.
    task automatic test_regs();
        #1;
        `CHK("mclks_rst", 7'h7F, mclks)
        `CHK("dom_rst", 6'h3F, domains)
        apb(1'b0, `OFS_PERIPHERAL_CLOCK_STOP, 32'h0);
        `CHK("pcs_rst", 32'h0, rd)
        `CHK("pready", 1'b1, pready)
        `CHK("conv_ext_rst", 1'b1, analog.converter_extended)
        // The converter is still off, so its clock may be stopped.
        apb(1'b1, `OFS_PERIPHERAL_CLOCK_STOP, 32'hFF);
        apb(1'b0, `OFS_PERIPHERAL_CLOCK_STOP, 32'h0);
        `CHK("pcs_rd", 32'hFD, rd)
        #1;
        `CHK("mclks_stop", 7'h0C, mclks)
        `CHK("mux_allow", 1'b0, analog.comparator_mux_allow)
        apb(1'b1, `OFS_PERIPHERAL_CLOCK_STOP, 32'h21);
        repeat (2) @(posedge mclk_in);
        #1;
        `CHK("mclks_map", 7'h6E, mclks)
        // The gated modules hold no state of their own here, so nothing needs reinitialising.
        apb(1'b1, `OFS_PERIPHERAL_CLOCK_STOP, 32'h0);
        repeat (2) @(posedge mclk_in);
        #1;
        `CHK("mclks_back", 7'h7F, mclks)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped_err", 1'b1, er)
        `CHK("unmapped_rd", 32'h0, rd)
        `CHK("ref_bod", 1'b1, analog.reference_enable)
    endtask

    // Refused entries: no enable, reserved code, standby without crystal.
    task automatic test_refused();
        apb(1'b1, `OFS_SLEEP_MODE_CONTROL, {28'h0, `MODE_POWER_DOWN, 1'b0});
        sleep_pulse();
        `CHK("no_enable", 1'b1, cpu_run)
        apb(1'b1, `OFS_SLEEP_MODE_CONTROL, {28'h0, 3'h3, 1'b1});
        sleep_pulse();
        `CHK("reserved", 1'b1, cpu_run)
        `CHK("reserved_dom", 6'h3F, domains)
        @(posedge mclk_in);
        crystal <= 1'b0;
        apb(1'b1, `OFS_SLEEP_MODE_CONTROL, {28'h0, `MODE_STANDBY, 1'b1});
        sleep_pulse();
        `CHK("stby_noxtal", 1'b1, cpu_run)
        @(posedge mclk_in);
        crystal <= 1'b1;
    endtask

    // Idle with converter on, then wake on an enabled interrupt.
    task automatic test_idle();
        @(posedge mclk_in);
        conv_on <= 1'b1;
        apb(1'b1, `OFS_SLEEP_MODE_CONTROL, {28'h0, `MODE_IDLE, 1'b1});
        sleep_pulse();
        `CHK("idle_dom", 6'h0F, domains)
        `CHK("idle_conv", 1'b1, analog.converter_enable)
        @(posedge mclk_in);
        irq_en <= 1'b1;
        wait_run();
        `CHK("idle_halt", 1'b1, n >= 5)
        `CHK("idle_wake", 1'b1, n <= 9)
        @(posedge mclk_in);
        irq_en <= 1'b0;
        conv_on <= 1'b0;
    endtask

    // Noise reduction, then power-down with wrong and right wake sources.
    task automatic test_power_down();
        apb(1'b1, `OFS_SLEEP_MODE_CONTROL, {28'h0, `MODE_NOISE, 1'b1});
        sleep_pulse();
        `CHK("noise_dom", 6'h07, domains)
        @(posedge mclk_in);
        irq_en <= 1'b1;
        wait_run();
        `CHK("noise_wake", 1'b1, cpu_run)
        @(posedge mclk_in);
        irq_en <= 1'b0;
        comp_on <= 1'b1;
        apb(1'b1, `OFS_SLEEP_MODE_CONTROL, {28'h0, `MODE_POWER_DOWN, 1'b1});
        sleep_pulse();
        `CHK("pd_dom", 6'h00, domains)
        `CHK("pd_mclks", 7'h00, mclks)
        `CHK("pd_comp", 1'b0, analog.comparator_enable)
        `CHK("pd_bod", 1'b1, analog.brownout_enable)
        @(posedge mclk_in);
        irq_en <= 1'b1;
        repeat (10) @(posedge mclk_in);
        #1;
        `CHK("pd_irq_only", 1'b0, cpu_run)
        @(posedge mclk_in);
        irq_en <= 1'b0;
        ext_lines <= 4'hB;
        wait_run();
        `CHK("pd_startup", 1'b1, n >= 9)
        `CHK("pd_wake", 1'b1, n <= 13)
        @(posedge mclk_in);
        ext_lines <= 4'hF;
        comp_on <= 1'b0;
    endtask

    // Standby keeps only the main source and wakes within six cycles.
    task automatic test_standby();
        apb(1'b1, `OFS_SLEEP_MODE_CONTROL, {28'h0, `MODE_STANDBY, 1'b1});
        sleep_pulse();
        `CHK("stby_dom", 6'h01, domains)
        @(posedge mclk_in);
        ext_lines <= 4'hE;
        wait_run();
        `CHK("stby_wake", 1'b1, n <= 8)
        @(posedge mclk_in);
        ext_lines <= 4'hF;
    endtask

    // ==========================================================
    // Verdict and main sequence
    task automatic stop_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Reset for eight cycles, then run every scenario.
    initial begin
        repeat (8) @(posedge mclk_in);
        reset_in <= 1'b0;
        test_regs();
        test_refused();
        test_idle();
        test_power_down();
        test_standby();
        stop_test();
    end
endmodule
